// ---- core/clock_mode_cfg.svh ----
`ifndef CLOCK_MODE_CFG_SVH
`define CLOCK_MODE_CFG_SVH

// Register offsets on the plain register port
`define CTRL1_ADDR 3'h0
`define CTRL2_ADDR 3'h1
`define TRIM_ADDR 3'h2
`define STATUS_ADDR 3'h3

// Reset values
`define CTRL1_RESET 8'h04
`define CTRL2_RESET 8'h40
`define TRIM_RESET 8'h80
`define FINE_RESET 1'h0

// Clock source codes, shared by select and state fields
`define SRC_FLL 2'h0
`define SRC_INT 2'h1
`define SRC_EXT 2'h2
`define SRC_RSV 2'h3

// Status field positions
`define ST_STATE_HI 3
`define ST_STATE_LO 2
`define ST_OSC_READY 1
`define ST_FINE 0

// Synchroniser bit positions
`define SY_INT 0
`define SY_EXT 1
`define SY_FLL 2
`define SY_STOP 3
`define SY_DBG 4
`define SY_OSC 5

// Timing counts in clk cycles or source edges
`define SWITCH_EDGES 3'h4
`define RELOCK_EDGES 3'h4
`define SWITCH_TIMEOUT 11'h400

`endif

// ---- core/clock_mode_pkg.sv ----
package clock_mode_pkg;

    typedef struct packed {
        logic [1:0] clock_source_select;
        logic [2:0] ref_divider;
        logic internal_ref_select;
        logic int_ref_out_enable;
        logic int_ref_stop_keep;
    } ctrl1_type;

    typedef struct packed {
        logic [1:0] bus_divider;
        logic osc_range;
        logic osc_high_gain;
        logic fll_power_down_in_bypass;
        logic ext_osc_request;
        logic ext_ref_out_enable;
        logic ext_ref_stop_keep;
    } ctrl2_type;

    typedef enum logic [2:0] {
        SW_IDLE = 3'h1,
        SW_WAIT = 3'h2,
        SW_SWAP = 3'h4
    } switch_state_type;

endpackage : clock_mode_pkg

// ---- core/fll_clock_mode_selector.sv ----
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "clock_mode_cfg.svh"

// Behaviour
// - Eight-bit trim lengthens internal reference period as value rises, binary weighted.
// - Fine trim bit adds smallest period step: set lengthens, clear shortens.
// - Mode state reports FLL, bypassed internal, or bypassed external (10); 11 reserved.
// - Mode state follows a source select write only after synchronisation.
// - Oscillator ready sets after startup when requested and external reference output enabled.
// - Oscillator ready clears only when external output enable or request clears.
// - Reset gives FLL engaged internal: source select 00, internal reference selected.
// - Engaged internal: system clock from FLL; debug clock and internal reference active.
// - Engaged external: FLL locks to divided external reference; debug clock available.
// - Bypassed internal, debug or no low power: FLL stays on, debug clock available.
// - Bypassed internal low power: FLL off, debug clock unavailable.
// - Bypassed external, debug or no low power: FLL stays on, debug clock available.
// - Bypassed external low power: FLL off, debug clock unavailable.
// - Stop halts all clocks; internal reference output kept if enabled and kept.
// - In stop external reference output runs only if enabled and kept.
// - After reference select change FLL relocks after a few divided reference cycles.
// - Source select change takes effect after a few cycles of the new clock.
// - Unavailable new source leaves the previous source driving the system clock.
// - Reference divider divides by two to the power of its code, 1 to 128.
// - Bus divider divides selected source by 1, 2, 4 or 8; resets to 2.
module fll_clock_mode_selector
    import clock_mode_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic int_ref_clk_in,
    input wire logic ext_ref_clk_in,
    input wire logic fll_clk_in,
    input wire logic stop_req,
    input wire logic debug_active,
    input wire logic osc_started,
    output logic system_clock_out,
    output logic debug_link_clock,
    output logic int_ref_clock_out,
    output logic ext_ref_clock_out,
    output logic fll_ref_clock,
    output logic fll_enable,
    output logic fll_relock,
    output logic osc_enable,
    output logic [8:0] ref_period_code,
    output logic [1:0] clock_mode_state
);

    ctrl1_type ctrl1;
    ctrl2_type ctrl2;
    logic [7:0] trim;
    logic fine_period_trim;
    logic osc_ready_flag;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    switch_state_type sw_state;
    logic [1:0] pend_src;
    logic [2:0] edge_cnt;
    logic [10:0] wait_cnt;
    logic [6:0] bus_cnt;
    logic [6:0] ref_cnt;
    logic internal_ref_select_prev;
    logic relock_busy;
    logic [2:0] relock_cnt;
    logic swap_now;
    logic stop_s;
    logic dbg_s;
    logic ext_mode;
    logic low_power_bypass;
    logic next_fll_enable;
    logic ref_lvl;
    logic ref_rise;
    logic next_div_ref;
    logic div_rise;

    function automatic logic src_level(input logic [1:0] sel, input logic [5:0] v);
        unique case (sel)
            `SRC_FLL: src_level = v[`SY_FLL];
            `SRC_INT: src_level = v[`SY_INT];
            `SRC_EXT: src_level = v[`SY_EXT];
            default: src_level = 1'b0;
        endcase
    endfunction : src_level

    // Divide by 2**sel using a rising-edge counter
    function automatic logic div_tap(input logic [6:0] cnt, input logic lvl, input logic [2:0] sel);
        if (sel == 3'h0) begin
            div_tap = lvl;
        end else begin
            div_tap = cnt[sel - 3'h1];
        end
    endfunction : div_tap

    // Two-flop synchronisers plus a third stage for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            sync3 <= 6'h00;
        end else begin
            sync1 <= {osc_started, debug_active, stop_req, fll_clk_in, ext_ref_clk_in, int_ref_clk_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign stop_s = sync2[`SY_STOP];
    assign dbg_s = sync2[`SY_DBG];

    // Register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl1 <= `CTRL1_RESET;
            ctrl2 <= `CTRL2_RESET;
            trim <= `TRIM_RESET;
            fine_period_trim <= `FINE_RESET;
        end else if (wr) begin
            unique case (addr)
                `CTRL1_ADDR: begin
                    ctrl1 <= wdata;
                    if (wdata[7:6] == `SRC_RSV) begin
                        ctrl1.clock_source_select <= `SRC_FLL;
                    end
                end
                `CTRL2_ADDR: ctrl2 <= wdata;
                `TRIM_ADDR: trim <= wdata;
                `STATUS_ADDR: fine_period_trim <= wdata[`ST_FINE];
                default: ;
            endcase
        end
    end

    // Read data valid in the cycle after the strobe only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= 8'h00;
            if (rd) begin
                unique case (addr)
                    `CTRL1_ADDR: rdata <= ctrl1;
                    `CTRL2_ADDR: rdata <= ctrl2;
                    `TRIM_ADDR: rdata <= trim;
                    `STATUS_ADDR: rdata <= {4'h0, clock_mode_state, osc_ready_flag, fine_period_trim};
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end

    // Period code: trim in upper bits, fine trim as the least step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_period_code <= {`TRIM_RESET, `FINE_RESET};
        end else begin
            ref_period_code <= {trim, fine_period_trim};
        end
    end

    // Oscillator request and ready flag
    assign ext_mode = (clock_mode_state == `SRC_EXT)
        || (clock_mode_state == `SRC_FLL && !ctrl1.internal_ref_select);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_enable <= 1'b0;
            osc_ready_flag <= 1'b0;
        end else begin
            osc_enable <= ctrl2.ext_osc_request && (ctrl2.ext_ref_out_enable || ext_mode);
            if (!ctrl2.ext_ref_out_enable || !ctrl2.ext_osc_request) begin
                osc_ready_flag <= 1'b0;
            end else if (ext_mode || ctrl2.ext_ref_out_enable) begin
                if (sync2[`SY_OSC]) begin
                    osc_ready_flag <= 1'b1;
                end
            end
        end
    end

    function automatic logic src_avail(input logic [1:0] sel, input logic osc_need, input logic osc_rdy);
        unique case (sel)
            `SRC_FLL: src_avail = 1'b1;
            `SRC_INT: src_avail = 1'b1;
            `SRC_EXT: src_avail = !osc_need || osc_rdy;
            default: src_avail = 1'b0;
        endcase
    endfunction : src_avail

    assign swap_now = (sw_state == SW_SWAP) && (ctrl1.clock_source_select == pend_src)
        && !src_level(clock_mode_state, sync2) && !src_level(pend_src, sync2);

    // Source switch sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_state <= SW_IDLE;
            clock_mode_state <= `SRC_FLL;
            pend_src <= `SRC_FLL;
            edge_cnt <= 3'h0;
            wait_cnt <= 11'h000;
        end else begin
            unique case (sw_state)
                SW_IDLE: begin
                    edge_cnt <= 3'h0;
                    wait_cnt <= 11'h000;
                    pend_src <= ctrl1.clock_source_select;
                    if (ctrl1.clock_source_select != clock_mode_state
                        && src_avail(ctrl1.clock_source_select, ctrl2.ext_osc_request, osc_ready_flag)) begin
                        sw_state <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    wait_cnt <= wait_cnt + 11'h001;
                    if (ctrl1.clock_source_select != pend_src || wait_cnt == `SWITCH_TIMEOUT) begin
                        sw_state <= SW_IDLE;
                    end else if (edge_cnt == `SWITCH_EDGES) begin
                        sw_state <= SW_SWAP;
                    end else if (src_level(pend_src, sync2) && !src_level(pend_src, sync3)) begin
                        edge_cnt <= edge_cnt + 3'h1;
                    end
                end
                SW_SWAP: begin
                    wait_cnt <= wait_cnt + 11'h001;
                    if (swap_now) begin
                        clock_mode_state <= pend_src;
                        sw_state <= SW_IDLE;
                    end else if (ctrl1.clock_source_select != pend_src || wait_cnt == `SWITCH_TIMEOUT) begin
                        sw_state <= SW_IDLE;
                    end
                end
            endcase
        end
    end

    // Bus divider on the active source
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_cnt <= 7'h00;
        end else if (swap_now) begin
            bus_cnt <= 7'h00;
        end else if (src_level(clock_mode_state, sync2) && !src_level(clock_mode_state, sync3)) begin
            bus_cnt <= bus_cnt + 7'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            system_clock_out <= 1'b0;
        end else begin
            system_clock_out <= !stop_s
                && div_tap(bus_cnt, src_level(clock_mode_state, sync2), {1'b0, ctrl2.bus_divider});
        end
    end

    // FLL power and debug link clock per mode
    assign low_power_bypass = (ctrl1.clock_source_select != `SRC_FLL)
        && ctrl2.fll_power_down_in_bypass && !dbg_s;
    assign next_fll_enable = !stop_s && !low_power_bypass;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fll_enable <= 1'b1;
            debug_link_clock <= 1'b0;
        end else begin
            fll_enable <= next_fll_enable;
            debug_link_clock <= next_fll_enable && sync2[`SY_FLL];
        end
    end

    // Reference outputs with stop-keep gating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_ref_clock_out <= 1'b0;
            ext_ref_clock_out <= 1'b0;
        end else begin
            int_ref_clock_out <= sync2[`SY_INT] && ctrl1.int_ref_out_enable
                && (!stop_s || ctrl1.int_ref_stop_keep);
            ext_ref_clock_out <= sync2[`SY_EXT] && ctrl2.ext_ref_out_enable
                && (!stop_s || ctrl2.ext_ref_stop_keep);
        end
    end

    // FLL reference divider
    assign ref_lvl = ctrl1.internal_ref_select ? sync2[`SY_INT] : sync2[`SY_EXT];
    assign ref_rise = ctrl1.internal_ref_select ? (sync2[`SY_INT] && !sync3[`SY_INT])
        : (sync2[`SY_EXT] && !sync3[`SY_EXT]);
    assign next_div_ref = !stop_s && div_tap(ref_cnt, ref_lvl, ctrl1.ref_divider);
    assign div_rise = next_div_ref && !fll_ref_clock;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_cnt <= 7'h00;
            fll_ref_clock <= 1'b0;
        end else begin
            fll_ref_clock <= next_div_ref;
            if (ref_rise) begin
                ref_cnt <= ref_cnt + 7'h01;
            end
        end
    end

    // Relock after reference select change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            internal_ref_select_prev <= 1'b1;
            relock_busy <= 1'b0;
            relock_cnt <= 3'h0;
            fll_relock <= 1'b0;
        end else begin
            internal_ref_select_prev <= ctrl1.internal_ref_select;
            fll_relock <= 1'b0;
            if (ctrl1.internal_ref_select != internal_ref_select_prev) begin
                relock_busy <= 1'b1;
                relock_cnt <= 3'h0;
            end else if (relock_busy && div_rise) begin
                if (relock_cnt == `RELOCK_EDGES - 3'h1) begin
                    fll_relock <= 1'b1;
                    relock_busy <= 1'b0;
                end else begin
                    relock_cnt <= relock_cnt + 3'h1;
                end
            end
        end
    end

    // Checks
    sequence src_write;
        wr && addr == `CTRL1_ADDR && wdata[7:6] != clock_mode_state && wdata[7:6] != `SRC_RSV;
    endsequence

    sequence switch_giveup;
        sw_state == SW_WAIT && ctrl1.clock_source_select == pend_src && wait_cnt == `SWITCH_TIMEOUT;
    endsequence

    a_state_lags_write: assert property (@(posedge clk) disable iff (rst)
        src_write |=> $stable(clock_mode_state) ##1 $stable(clock_mode_state))
        else $error("mode state changed right after select write");

    a_giveup_keeps_src: assert property (@(posedge clk) disable iff (rst)
        switch_giveup |=> sw_state == SW_IDLE && $stable(clock_mode_state))
        else $error("failed switch changed the source");

    a_stop_halts_sys: assert property (@(posedge clk) disable iff (rst)
        stop_s |=> !system_clock_out && !debug_link_clock)
        else $error("system clock running in stop");

    a_stop_int_ref: assert property (@(posedge clk) disable iff (rst)
        stop_s && !(ctrl1.int_ref_out_enable && ctrl1.int_ref_stop_keep) |=> !int_ref_clock_out)
        else $error("internal reference output running in stop");

    a_stop_ext_ref: assert property (@(posedge clk) disable iff (rst)
        stop_s && !(ctrl2.ext_ref_out_enable && ctrl2.ext_ref_stop_keep) |=> !ext_ref_clock_out)
        else $error("external reference output running in stop");

    a_osc_ready_clear: assert property (@(posedge clk) disable iff (rst)
        !ctrl2.ext_ref_out_enable || !ctrl2.ext_osc_request |=> !osc_ready_flag)
        else $error("oscillator ready not cleared");

    a_osc_ready_hold: assert property (@(posedge clk) disable iff (rst)
        osc_ready_flag && ctrl2.ext_ref_out_enable && ctrl2.ext_osc_request |=> osc_ready_flag)
        else $error("oscillator ready lost without cause");

    a_low_power_dbg: assert property (@(posedge clk) disable iff (rst)
        low_power_bypass |=> !fll_enable && !debug_link_clock)
        else $error("FLL or debug clock on in low-power bypass");

    a_fll_engaged_on: assert property (@(posedge clk) disable iff (rst)
        ctrl1.clock_source_select == `SRC_FLL && !stop_s |=> fll_enable)
        else $error("FLL off in engaged mode");

endmodule : fll_clock_mode_selector

// ---- testbench/ext_osc_model.sv ----
`timescale 1ns/1ps
module ext_osc_model #(
    parameter real HALF_NS = 130.0,
    parameter int STARTUP_NS = 20000
) (
    input wire logic osc_enable,
    input wire logic clock_hold,
    output logic ext_ref_clk_in,
    output logic osc_started
);
    // External source runs free unless held low
    initial begin
        ext_ref_clk_in = 1'b0;
        forever #(HALF_NS) ext_ref_clk_in = !clock_hold && !ext_ref_clk_in;
    end
    // Startup cycles only while requested
    initial begin
        osc_started = 1'b0;
        forever begin
            wait (osc_enable);
            #(STARTUP_NS);
            osc_started = osc_enable;
            wait (!osc_enable);
            osc_started = 1'b0;
        end
    end
endmodule : ext_osc_model

// ---- testbench/fll_clock_mode_selector_tb.sv ----
`timescale 1ns/1ps
`include "clock_mode_cfg.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module fll_clock_mode_selector_tb
    import clock_mode_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic int_ref_clk_in = 1'b0, fll_clk_in = 1'b0, stop_req = 1'b0, debug_active = 1'b0, ext_hold = 1'b0;
    logic ext_ref_clk_in, osc_started, osc_enable, fll_relock, fll_enable;
    logic system_clock_out, debug_link_clock, int_ref_clock_out, ext_ref_clock_out, fll_ref_clock;
    logic [8:0] ref_period_code;
    logic [1:0] clock_mode_state;
    logic [4:0] mon;
    int bad_count = 0, tests_run = 0, cyc = 0, n;
    assign mon = {system_clock_out, debug_link_clock, int_ref_clock_out, ext_ref_clock_out, fll_ref_clock};

    always #12.5 clk = ~clk;
    always #110 int_ref_clk_in = ~int_ref_clk_in;
    always #60 fll_clk_in = ~fll_clk_in;

    fll_clock_mode_selector u_fll_clock_mode_selector (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .int_ref_clk_in(int_ref_clk_in), .ext_ref_clk_in(ext_ref_clk_in),
        .fll_clk_in(fll_clk_in), .stop_req(stop_req), .debug_active(debug_active), .osc_started(osc_started),
        .system_clock_out(system_clock_out), .debug_link_clock(debug_link_clock),
        .int_ref_clock_out(int_ref_clock_out), .ext_ref_clock_out(ext_ref_clock_out),
        .fll_ref_clock(fll_ref_clock), .fll_enable(fll_enable), .fll_relock(fll_relock),
        .osc_enable(osc_enable), .ref_period_code(ref_period_code), .clock_mode_state(clock_mode_state));

    ext_osc_model u_ext_osc_model (.osc_enable(osc_enable), .clock_hold(ext_hold),
        .ext_ref_clk_in(ext_ref_clk_in), .osc_started(osc_started));

    task automatic report_and_stop();
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic count_rises(input int idx, input int ncyc);
        logic prev;
        prev = mon[idx];
        n = 0;
        repeat (ncyc) begin
            @(posedge clk);
            #1;
            if (mon[idx] === 1'b1 && prev === 1'b0) n++;
            prev = mon[idx];
        end
    endtask : count_rises

    task automatic near(input string nm, input int e);
        `CHK(nm, 1'b1, (n >= e - 3 && n <= e + 3));
    endtask : near

    task automatic wait_state(input logic [1:0] s, input int lim);
        for (int i = 0; i < lim && clock_mode_state !== s; i++) begin
            @(posedge clk);
            #1;
        end
        `CHK("clock_mode_state", s, clock_mode_state);
    endtask : wait_state

    task automatic t_reset();
        rd_reg(`CTRL1_ADDR); `CHK("ctrl1", 8'h04, d);
        rd_reg(`CTRL2_ADDR); `CHK("ctrl2", 8'h40, d);
        rd_reg(`STATUS_ADDR); `CHK("status", 8'h00, d);
        rd_reg(`TRIM_ADDR); `CHK("trim", 8'h80, d);
        `CHK("period code", 9'h100, ref_period_code);
        `CHK("osc_enable", 1'b0, osc_enable);
        rd_reg(3'h5); `CHK("unmapped", 8'h00, d);
        `CHK("fll_enable", 1'b1, fll_enable);
        count_rises(3, 100); `CHK("debug clock runs", 1'b1, n > 0);
    endtask : t_reset

    task automatic t_trim();
        wr_reg(`TRIM_ADDR, 8'h81);
        wr_reg(`STATUS_ADDR, 8'hF1);
        rd_reg(`STATUS_ADDR); `CHK("status fine", 8'h01, d);
        #1 `CHK("period code", 9'h103, ref_period_code);
        wr_reg(`TRIM_ADDR, 8'h7F);
        @(posedge clk);
        #1 `CHK("period code", 9'h0FF, ref_period_code);
        wr_reg(`STATUS_ADDR, 8'h00);
        @(posedge clk);
        #1 `CHK("period code", 9'h0FE, ref_period_code);
        wr_reg(`STATUS_ADDR, 8'h01);
    endtask : t_trim

    task automatic t_int_modes();
        wr_reg(`CTRL1_ADDR, 8'h44);
        #1 `CHK("state lags", 2'h0, clock_mode_state);
        wait_state(2'h1, 100);
        count_rises(0, 880); near("ref div 1", 100);
        wr_reg(`CTRL1_ADDR, 8'h4C);
        count_rises(0, 880); near("ref div 2", 50);
        count_rises(4, 880); near("bus div 2", 50);
        wr_reg(`CTRL2_ADDR, 8'h00);
        count_rises(4, 880); near("bus div 1", 100);
        wr_reg(`CTRL2_ADDR, 8'hC0);
        count_rises(4, 880); near("bus div 8", 12);
        wr_reg(`CTRL2_ADDR, 8'h48);
        repeat (8) @(posedge clk);
        #1 `CHK("fll off low power", 1'b0, fll_enable);
        count_rises(3, 200); `CHK("debug clock idle", 0, n);
        @(posedge clk);
        debug_active <= 1'b1;
        repeat (8) @(posedge clk);
        #1 `CHK("fll on in debug", 1'b1, fll_enable);
        count_rises(3, 200); `CHK("debug clock runs", 1'b1, n > 0);
        @(posedge clk);
        debug_active <= 1'b0;
        wr_reg(`CTRL2_ADDR, 8'h40);
    endtask : t_int_modes

    task automatic t_stop();
        wr_reg(`CTRL1_ADDR, 8'h47);
        wr_reg(`CTRL2_ADDR, 8'h42);
        count_rises(1, 200); `CHK("ext out runs", 1'b1, n > 0);
        @(posedge clk);
        stop_req <= 1'b1;
        repeat (10) @(posedge clk);
        count_rises(2, 200); `CHK("int out kept", 1'b1, n > 0);
        count_rises(1, 200); `CHK("ext out stopped", 0, n);
        count_rises(4, 200); `CHK("system clock stopped", 0, n);
        count_rises(0, 200); `CHK("fll ref stopped", 0, n);
        wr_reg(`CTRL2_ADDR, 8'h43);
        count_rises(1, 200); `CHK("ext out kept", 1'b1, n > 0);
        wr_reg(`CTRL1_ADDR, 8'h46);
        count_rises(2, 200); `CHK("int out stopped", 0, n);
        @(posedge clk);
        stop_req <= 1'b0;
        wr_reg(`CTRL1_ADDR, 8'h44);
    endtask : t_stop

    task automatic t_hold();
        @(posedge clk);
        ext_hold <= 1'b1;
        wr_reg(`CTRL1_ADDR, 8'h84);
        repeat (1100) @(posedge clk);
        #1 `CHK("held source kept", 2'h1, clock_mode_state);
        @(posedge clk);
        ext_hold <= 1'b0;
        wait_state(2'h2, 300);
        wr_reg(`CTRL1_ADDR, 8'h44);
        wait_state(2'h1, 300);
    endtask : t_hold

    task automatic t_ext();
        logic seen;
        seen = 1'b0;
        wr_reg(`CTRL2_ADDR, 8'h46);
        wr_reg(`CTRL1_ADDR, 8'h80);
        repeat (200) begin
            @(posedge clk);
            #1 if (fll_relock === 1'b1) seen = 1'b1;
        end
        `CHK("relock pulse", 1'b1, seen);
        `CHK("source kept", 2'h1, clock_mode_state);
        `CHK("osc_enable", 1'b1, osc_enable);
        rd_reg(`STATUS_ADDR); `CHK("osc not ready", 8'h05, d);
        wait (osc_started === 1'b1);
        wait_state(2'h2, 300);
        `CHK("fll on bypassed ext", 1'b1, fll_enable);
        rd_reg(`STATUS_ADDR); `CHK("status ext", 8'h0B, d);
        wr_reg(`TRIM_ADDR, 8'h10);
        wr_reg(`CTRL2_ADDR, 8'h4E);
        repeat (8) @(posedge clk);
        #1 `CHK("fll off ext low power", 1'b0, fll_enable);
        count_rises(3, 200); `CHK("debug clock idle ext", 0, n);
        rd_reg(`STATUS_ADDR); `CHK("osc ready kept", 8'h0B, d);
        wr_reg(`CTRL2_ADDR, 8'h44);
        rd_reg(`STATUS_ADDR); `CHK("osc ready cleared", 8'h09, d);
        wr_reg(`CTRL1_ADDR, 8'h00);
        wait_state(2'h0, 100);
        `CHK("fll on engaged ext", 1'b1, fll_enable);
        count_rises(0, 520); near("ext ref div 1", 50);
    endtask : t_ext

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_trim();
        t_int_modes();
        t_stop();
        t_hold();
        t_ext();
        report_and_stop();
    end
endmodule : fll_clock_mode_selector_tb
